// ### hdl/bus_cfg_pkg.sv
package bus_cfg_pkg;

  localparam logic [15:0] ARB_INTERLOCK_A_OFS    = 16'h2035;
  localparam logic [15:0] ARB_INTERLOCK_B_OFS    = 16'h2037;
  localparam logic [15:0] CABLE_REQ_PARITY_OFS   = 16'h2065;
  localparam logic [15:0] CABLE_TIMEOUT_OFS      = 16'h2067;
  localparam logic [15:0] BACKPLANE_REQ_OFS      = 16'h20B5;

  localparam logic [7:0]  ARB_INTERLOCK_RESET    = 8'h00;
  localparam logic [7:0]  CABLE_REQ_PARITY_RESET = 8'hE5;
  localparam logic [7:0]  CABLE_TIMEOUT_RESET    = 8'h08;
  localparam logic [7:0]  BACKPLANE_REQ_RESET    = 8'h07;

  localparam int          BP_LEVEL_LSB           = 0;
  localparam int          BP_UNFAIR_BIT          = 4;
  localparam int          CABLE_FAIR_BIT         = 5;
  localparam int          CABLE_PARITY_BIT       = 2;
  localparam int          TIMEOUT_CODE_W         = 4;

  localparam int          CLOCK_MHZ              = 200;
  // timeout table in microseconds, index = code
  localparam int          TIMEOUT_US [16] = '{0, 8, 15, 30, 60, 125, 250, 500, 1000, 2000, 4000, 8000,
                                              16000, 32000, 64000, 128000};
  localparam int          LOAD_CYCLES            = 2;

  typedef struct packed {
    logic [1:0] level;
    logic       unfair;
  } backplane_req_t;

  typedef struct packed {
    logic       fair;
    logic       parity_check;
  } cable_req_t;

  typedef struct packed {
    logic        write;
    logic        read;
    logic [15:0] offset;
    logic [7:0]  data;
  } cfg_access_t;

endpackage : bus_cfg_pkg

// ### hdl/cable_watchdog.sv
`timescale 1ns/1ps
module cable_watchdog #(
  parameter int SCALE = 1
) (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic [3:0] code,
  input  wire logic       enable,
  input  wire logic       cycle_active,
  input  wire logic       slave_response,
  output logic            expired
);
  logic [31:0] count;
  logic [31:0] next_count;
  logic [31:0] limit;
  logic        next_expired;

  always_comb begin
    limit = 32'(bus_cfg_pkg::TIMEOUT_US[code] * bus_cfg_pkg::CLOCK_MHZ / SCALE);
    next_count = 32'h0;
    next_expired = 1'b0;
    if (enable && cycle_active && !slave_response && code != 4'h0 && !expired) begin
      next_count = count + 32'h1;
      if (next_count >= limit) begin
        next_expired = 1'b1;
        next_count = 32'h0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      count   <= 32'h0;
      expired <= 1'b0;
    end else begin
      count   <= next_count;
      expired <= next_expired;
    end
  end
endmodule : cable_watchdog

// ### hdl/bus_requester_timeout_config.sv
`timescale 1ns/1ps
module bus_requester_timeout_config #(
  parameter int TIMEOUT_SCALE = 1
) (
  input  wire logic        CLOCK,
  input  wire logic        RST,
  input  wire logic        CFG_WRITE,
  input  wire logic        CFG_READ,
  input  wire logic [15:0] CFG_OFFSET,
  input  wire logic [7:0]  CFG_WDATA,
  output logic      [7:0]  CFG_RDATA,
  output logic             CFG_RVALID,
  input  wire logic        CABLE_LOCAL_ACCESS,
  input  wire logic        BP_GRANT,
  input  wire logic        BP_OTHER_REQ,
  input  wire logic        BP_XFER_DONE,
  output logic      [3:0]  BP_REQUEST,
  output logic             BP_BUSY,
  input  wire logic        CABLE_WANT,
  input  wire logic        CABLE_OTHER_REQ,
  input  wire logic        CABLE_GRANT,
  output logic             CABLE_REQUEST,
  input  wire logic        SYS_CONTROLLER,
  input  wire logic        CABLE_CYCLE_ACTIVE,
  input  wire logic        CABLE_SLAVE_RESPONSE,
  input  wire logic        CABLE_MAPS_TO_MAINFRAME,
  output logic             CABLE_TIMEOUT_TERMINATE,
  input  wire logic [31:0] TX_DATA,
  output logic             TX_PARITY,
  input  wire logic [31:0] RX_DATA,
  input  wire logic        RX_PARITY,
  input  wire logic        RX_VALID,
  output logic             RX_PARITY_ERROR,
  output logic             INTERLOCKED,
  output logic             READY
);

  ////////////////////////////////////////////////////////////////////////////
  // configuration bytes

  logic [7:0] arb_a, arb_b, cable_rp, cable_to, bp_req;
  logic [7:0] next_arb_a, next_arb_b, next_cable_rp, next_cable_to, next_bp_req;
  logic [7:0] next_rdata;
  logic       next_rvalid;

  always_comb begin
    next_arb_a    = arb_a;
    next_arb_b    = arb_b;
    next_cable_rp = cable_rp;
    next_cable_to = cable_to;
    next_bp_req   = bp_req;
    next_rdata    = 8'h00;
    next_rvalid   = CFG_READ;
    if (CFG_WRITE) begin
      case (CFG_OFFSET)
        bus_cfg_pkg::ARB_INTERLOCK_A_OFS:  next_arb_a    = CFG_WDATA;
        bus_cfg_pkg::ARB_INTERLOCK_B_OFS:  next_arb_b    = CFG_WDATA;
        bus_cfg_pkg::CABLE_REQ_PARITY_OFS: next_cable_rp = CFG_WDATA;
        bus_cfg_pkg::CABLE_TIMEOUT_OFS:    next_cable_to = CFG_WDATA;
        bus_cfg_pkg::BACKPLANE_REQ_OFS:    next_bp_req   = CFG_WDATA;
        default: begin
        end
      endcase
    end
    if (CFG_READ) begin
      case (CFG_OFFSET)
        bus_cfg_pkg::ARB_INTERLOCK_A_OFS:  next_rdata = arb_a;
        bus_cfg_pkg::ARB_INTERLOCK_B_OFS:  next_rdata = arb_b;
        bus_cfg_pkg::CABLE_REQ_PARITY_OFS: next_rdata = cable_rp;
        bus_cfg_pkg::CABLE_TIMEOUT_OFS:    next_rdata = cable_to;
        bus_cfg_pkg::BACKPLANE_REQ_OFS:    next_rdata = bp_req;
        default:                           next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      arb_a      <= bus_cfg_pkg::ARB_INTERLOCK_RESET;
      arb_b      <= bus_cfg_pkg::ARB_INTERLOCK_RESET;
      cable_rp   <= bus_cfg_pkg::CABLE_REQ_PARITY_RESET;
      cable_to   <= bus_cfg_pkg::CABLE_TIMEOUT_RESET;
      bp_req     <= bus_cfg_pkg::BACKPLANE_REQ_RESET;
      CFG_RDATA  <= 8'h00;
      CFG_RVALID <= 1'b0;
    end else begin
      arb_a      <= next_arb_a;
      arb_b      <= next_arb_b;
      cable_rp   <= next_cable_rp;
      cable_to   <= next_cable_to;
      bp_req     <= next_bp_req;
      CFG_RDATA  <= next_rdata;
      CFG_RVALID <= next_rvalid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decoded settings, reloaded from the configuration bytes every cycle

  bus_cfg_pkg::backplane_req_t bp_set, next_bp_set;
  bus_cfg_pkg::cable_req_t     cable_set, next_cable_set;
  logic [3:0] to_code, next_to_code;
  logic       ilock, next_ilock;
  logic [1:0] load_cnt, next_load_cnt;
  logic       next_ready;

  always_comb begin
    next_bp_set.level          = bp_req[bus_cfg_pkg::BP_LEVEL_LSB +: 2];
    next_bp_set.unfair         = bp_req[bus_cfg_pkg::BP_UNFAIR_BIT];
    next_cable_set.fair        = cable_rp[bus_cfg_pkg::CABLE_FAIR_BIT];
    next_cable_set.parity_check = cable_rp[bus_cfg_pkg::CABLE_PARITY_BIT];
    next_to_code               = cable_to[bus_cfg_pkg::TIMEOUT_CODE_W-1:0];
    next_ilock                 = arb_a[0] & arb_b[0];
    next_load_cnt              = load_cnt;
    next_ready                 = READY;
    if (load_cnt != 2'(bus_cfg_pkg::LOAD_CYCLES)) begin
      next_load_cnt = load_cnt + 2'h1;
    end else begin
      next_ready = 1'b1;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      bp_set    <= '0;
      cable_set <= '0;
      to_code   <= 4'h0;
      ilock     <= 1'b0;
      load_cnt  <= 2'h0;
      READY     <= 1'b0;
    end else begin
      bp_set    <= next_bp_set;
      cable_set <= next_cable_set;
      to_code   <= next_to_code;
      ilock     <= next_ilock;
      load_cnt  <= next_load_cnt;
      READY     <= next_ready;
    end
  end

  assign INTERLOCKED = ilock;

  ////////////////////////////////////////////////////////////////////////////
  // backplane requester

  typedef enum logic [1:0] {BP_IDLE, BP_REQ, BP_OWN} bp_state_t;
  bp_state_t bp_state, next_bp_state;
  logic      req_pulse_level;
  logic      cable_owned;
  logic      want_bp;

  always_comb begin
    want_bp = READY && CABLE_LOCAL_ACCESS && !(ilock && cable_owned);
    next_bp_state = bp_state;
    case (bp_state)
      BP_IDLE: begin
        if (want_bp && (bp_set.unfair || !BP_OTHER_REQ)) begin
          next_bp_state = BP_REQ;
        end
      end
      BP_REQ: begin
        if (BP_GRANT) begin
          next_bp_state = BP_OWN;
        end
      end
      BP_OWN: begin
        if (BP_XFER_DONE && (BP_OTHER_REQ || !want_bp)) begin
          next_bp_state = BP_IDLE;
        end
      end
      default: next_bp_state = BP_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      bp_state <= BP_IDLE;
    end else begin
      bp_state <= next_bp_state;
    end
  end

  assign req_pulse_level = (bp_state == BP_REQ);
  assign BP_REQUEST      = req_pulse_level ? (4'h1 << bp_set.level) : 4'h0;
  assign BP_BUSY         = (bp_state == BP_OWN);

  ////////////////////////////////////////////////////////////////////////////
  // cable requester

  logic cable_req, next_cable_req;

  always_comb begin
    next_cable_req = cable_req;
    if (!cable_req) begin
      if (READY && CABLE_WANT && !(ilock && BP_BUSY) &&
          (!cable_set.fair || !CABLE_OTHER_REQ)) begin
        next_cable_req = 1'b1;
      end
    end else if (!CABLE_WANT) begin
      next_cable_req = 1'b0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      cable_req <= 1'b0;
    end else begin
      cable_req <= next_cable_req;
    end
  end

  assign CABLE_REQUEST = cable_req;
  assign cable_owned   = cable_req && CABLE_GRANT;

  ////////////////////////////////////////////////////////////////////////////
  // cable watchdog

  cable_watchdog #(
    .SCALE(TIMEOUT_SCALE)
  ) u_watchdog (
    .clock          (CLOCK),
    .rst            (RST),
    .code           (to_code),
    .enable         (SYS_CONTROLLER && !CABLE_MAPS_TO_MAINFRAME && READY),
    .cycle_active   (CABLE_CYCLE_ACTIVE),
    .slave_response (CABLE_SLAVE_RESPONSE),
    .expired        (CABLE_TIMEOUT_TERMINATE)
  );

  ////////////////////////////////////////////////////////////////////////////
  // parity

  logic tx_par, next_tx_par, rx_err, next_rx_err;

  always_comb begin
    next_tx_par = ^TX_DATA;
    next_rx_err = RX_VALID && cable_set.parity_check && ((^RX_DATA) != RX_PARITY);
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      tx_par <= 1'b0;
      rx_err <= 1'b0;
    end else begin
      tx_par <= next_tx_par;
      rx_err <= next_rx_err;
    end
  end

  assign TX_PARITY       = tx_par;
  assign RX_PARITY_ERROR = rx_err;

endmodule : bus_requester_timeout_config

// ### tb/bp_model.sv
`timescale 1ns/1ps
module bp_model (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic [3:0] bp_request,
  input  wire logic       bp_busy,
  input  wire logic       slow,
  output logic            bp_grant,
  output logic            bp_xfer_done
);
  logic [3:0] wait_cnt;
  // grant after a prompt or slow delay, then end the transfer later
  always @(posedge clock) begin
    if (rst || (bp_request == 4'h0 && !bp_busy)) begin
      wait_cnt     <= 4'h0;
      bp_grant     <= 1'b0;
      bp_xfer_done <= 1'b0;
    end else begin
      wait_cnt     <= (wait_cnt == 4'hF) ? wait_cnt : wait_cnt + 4'h1;
      bp_grant     <= wait_cnt >= (slow ? 4'h6 : 4'h1);
      bp_xfer_done <= bp_busy && wait_cnt >= (slow ? 4'hC : 4'h4);
    end
  end
endmodule : bp_model

// ### tb/brtc_sva.sv
`timescale 1ns/1ps
module brtc_sva #(
  parameter int TIMEOUT_SCALE = 1
) (
  input wire logic        CLOCK,
  input wire logic        RST,
  input wire logic        CFG_READ,
  input wire logic        CFG_RVALID,
  input wire logic [3:0]  BP_REQUEST,
  input wire logic        BP_BUSY,
  input wire logic        BP_XFER_DONE,
  input wire logic        BP_OTHER_REQ,
  input wire logic        CABLE_WANT,
  input wire logic        CABLE_REQUEST,
  input wire logic        SYS_CONTROLLER,
  input wire logic        CABLE_MAPS_TO_MAINFRAME,
  input wire logic        CABLE_TIMEOUT_TERMINATE,
  input wire logic [31:0] TX_DATA,
  input wire logic        TX_PARITY,
  input wire logic [31:0] RX_DATA,
  input wire logic        RX_PARITY,
  input wire logic        RX_VALID,
  input wire logic        RX_PARITY_ERROR,
  input wire logic        INTERLOCKED,
  input wire logic        READY
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  sequence s_yield;
    BP_BUSY && BP_XFER_DONE && BP_OTHER_REQ;
  endsequence
  AST_ONE_LEVEL: assert property ($onehot0(BP_REQUEST)) else $error("several levels");
  AST_YIELD: assert property (s_yield |=> !BP_BUSY) else $error("bus kept");
  AST_TERM_COND: assert property (CABLE_TIMEOUT_TERMINATE |-> $past(SYS_CONTROLLER && !CABLE_MAPS_TO_MAINFRAME))
    else $error("terminate while inactive");
  AST_TX_PAR: assert property (!$past(RST) |-> TX_PARITY == ^$past(TX_DATA)) else $error("bad parity");
  AST_RX_ERR: assert property (RX_PARITY_ERROR |-> $past(RX_VALID && (RX_PARITY != ^RX_DATA)))
    else $error("false parity error");
  AST_READY: assert property (!READY |-> BP_REQUEST == 4'h0 && !CABLE_REQUEST) else $error("early request");
  AST_RVALID: assert property (!$past(RST) |-> CFG_RVALID == $past(CFG_READ)) else $error("read answer");
  AST_CABLE_DROP: assert property (!CABLE_WANT |=> !CABLE_REQUEST) else $error("request held");
  AST_INTERLOCK: assert property ($rose(CABLE_REQUEST) && $past(INTERLOCKED) |-> !$past(BP_BUSY))
    else $error("two owners");
endmodule : brtc_sva
bind bus_requester_timeout_config brtc_sva #(.TIMEOUT_SCALE(TIMEOUT_SCALE)) i_sva (.CLOCK, .RST, .CFG_READ,
  .CFG_RVALID, .BP_REQUEST, .BP_BUSY, .BP_XFER_DONE, .BP_OTHER_REQ, .CABLE_WANT, .CABLE_REQUEST, .SYS_CONTROLLER,
  .CABLE_MAPS_TO_MAINFRAME, .CABLE_TIMEOUT_TERMINATE, .TX_DATA, .TX_PARITY, .RX_DATA, .RX_PARITY, .RX_VALID,
  .RX_PARITY_ERROR, .INTERLOCKED, .READY);

// ### tb/bus_requester_timeout_config_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; $display("unexpected %s exp %h got %h", n, e, g); end end
module bus_requester_timeout_config_tb;
  logic        CLOCK, RST, CFG_WRITE, CFG_READ, CABLE_LOCAL_ACCESS, BP_GRANT, BP_OTHER_REQ, BP_XFER_DONE;
  logic        CABLE_WANT, CABLE_OTHER_REQ, CABLE_GRANT, SYS_CONTROLLER, CABLE_CYCLE_ACTIVE, CABLE_SLAVE_RESPONSE;
  logic        CABLE_MAPS_TO_MAINFRAME, RX_PARITY, RX_VALID, CFG_RVALID, BP_BUSY, CABLE_REQUEST, TX_PARITY;
  logic        CABLE_TIMEOUT_TERMINATE, RX_PARITY_ERROR, INTERLOCKED, READY, slow;
  logic [15:0] CFG_OFFSET;
  logic [7:0]  CFG_WDATA, CFG_RDATA, d;
  logic [3:0]  BP_REQUEST, seen;
  logic [31:0] TX_DATA, RX_DATA, rnd;
  int          n_fail, tests_run, t;
  localparam logic [15:0] OFS [6] = '{16'h2035, 16'h2037, 16'h2065, 16'h2067, 16'h20B5, 16'h2036};
  localparam logic [7:0]  RV [6]  = '{8'h00, 8'h00, 8'hE5, 8'h08, 8'h07, 8'h00};
  localparam logic [7:0]  CP [4]  = '{8'hE5, 8'hC5, 8'hE1, 8'hC1};
  // controller, maps, response, expected, code
  localparam logic [7:0]  WD [7]  = '{8'h98, 8'h92, 8'h02, 8'hC2, 8'hA2, 8'h80, 8'h91};
  bus_requester_timeout_config #(.TIMEOUT_SCALE(1000)) i_dut (.CLOCK, .RST, .CFG_WRITE, .CFG_READ, .CFG_OFFSET,
    .CFG_WDATA, .CFG_RDATA, .CFG_RVALID, .CABLE_LOCAL_ACCESS, .BP_GRANT, .BP_OTHER_REQ, .BP_XFER_DONE, .BP_REQUEST,
    .BP_BUSY, .CABLE_WANT, .CABLE_OTHER_REQ, .CABLE_GRANT, .CABLE_REQUEST, .SYS_CONTROLLER, .CABLE_CYCLE_ACTIVE,
    .CABLE_SLAVE_RESPONSE, .CABLE_MAPS_TO_MAINFRAME, .CABLE_TIMEOUT_TERMINATE, .TX_DATA, .TX_PARITY, .RX_DATA,
    .RX_PARITY, .RX_VALID, .RX_PARITY_ERROR, .INTERLOCKED, .READY);
  bp_model i_bp (.clock(CLOCK), .rst(RST), .bp_request(BP_REQUEST), .bp_busy(BP_BUSY), .slow,
    .bp_grant(BP_GRANT), .bp_xfer_done(BP_XFER_DONE));
  always @(posedge CLOCK) CABLE_GRANT <= CABLE_REQUEST;
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [3:0] exp_req(int i, logic other);
    return (i[2] || !other) ? 4'h1 << i[1:0] : 4'h0;
  endfunction : exp_req
  function automatic int ticks(logic [3:0] c);
    return bus_cfg_pkg::TIMEOUT_US[c] * 200 / 1000;
  endfunction : ticks
  task automatic cyc(int n);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask : cyc
  task automatic wait_for(ref logic s, input logic v, input int lim);
    t = 0;
    while (s !== v && t < lim) begin
      cyc(1);
      t++;
    end
  endtask : wait_for
  task automatic rd(logic [15:0] a, output logic [7:0] v);
    @(posedge CLOCK);
    CFG_READ   <= 1'b1;
    CFG_OFFSET <= a;
    @(posedge CLOCK);
    CFG_READ <= 1'b0;
    #1 `CHK("read valid", 1'b1, CFG_RVALID)
    v = CFG_RDATA;
  endtask : rd
  task automatic wr(logic [15:0] a, logic [7:0] v);
    int k;
    k = 0;
    @(posedge CLOCK);
    CFG_WRITE  <= 1'b1;
    CFG_OFFSET <= a;
    CFG_WDATA  <= v;
    @(posedge CLOCK);
    CFG_WRITE <= 1'b0;
    do rd(a, d); while (d !== v && ++k < 4);
    `CHK("read back", v, d)
  endtask : wr
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict
  initial begin
    CLOCK = 1'b0;
    forever #2.5 CLOCK = ~CLOCK;
  end
  initial begin
    #100000;
    n_fail++;
    give_verdict();
  end
  initial begin
    {CFG_WRITE, CFG_READ, CABLE_LOCAL_ACCESS, BP_OTHER_REQ, CABLE_WANT, CABLE_OTHER_REQ, CABLE_GRANT, slow} = '0;
    {SYS_CONTROLLER, CABLE_CYCLE_ACTIVE, CABLE_SLAVE_RESPONSE, CABLE_MAPS_TO_MAINFRAME, RX_PARITY, RX_VALID} = '0;
    {CFG_OFFSET, CFG_WDATA, TX_DATA, RX_DATA} = '0;
    RST = 1'b1;
    rnd = 32'h6542;
    n_fail = 0;
    tests_run = 0;
    cyc(2);
    RST <= 1'b0;
    cyc(4);
    `CHK("ready", 1'b1, READY)
    for (int i = 0; i < 6; i++) begin
      rd(OFS[i], d);
      `CHK("reset value", RV[i], d)
    end
    $display("test reset values done");
    for (int i = 0; i < 8; i++) begin
      wr(bus_cfg_pkg::BACKPLANE_REQ_OFS, 8'h04 | 8'(i[1:0]) | (i[2] ? 8'h10 : 8'h00));
      rnd = lfsr(rnd);
      slow <= rnd[3];
      BP_OTHER_REQ <= rnd[0];
      CABLE_LOCAL_ACCESS <= 1'b1;
      seen = 4'h0;
      repeat (8) begin
        cyc(1);
        seen |= BP_REQUEST;
      end
      `CHK("request level", exp_req(i, rnd[0]), seen)
      CABLE_LOCAL_ACCESS <= 1'b0;
      BP_OTHER_REQ <= 1'b0;
      t = 0;
      while ((BP_BUSY !== 1'b0 || BP_REQUEST !== 4'h0) && t < 60) begin
        cyc(1);
        t++;
      end
      `CHK("released", 1'b0, BP_BUSY)
      `CHK("request dropped", 4'h0, BP_REQUEST)
    end
    $display("test backplane requester done");
    for (int i = 0; i < 4; i++) begin
      wr(bus_cfg_pkg::CABLE_REQ_PARITY_OFS, CP[i]);
      rnd = lfsr(rnd);
      CABLE_OTHER_REQ <= 1'b1;
      CABLE_WANT <= 1'b1;
      TX_DATA <= rnd;
      RX_DATA <= rnd;
      RX_PARITY <= ~^rnd;
      RX_VALID <= 1'b1;
      cyc(1);
      RX_VALID <= 1'b0;
      `CHK("tx parity", ^rnd, TX_PARITY)
      `CHK("parity error", ~i[1], RX_PARITY_ERROR)
      cyc(2);
      `CHK("cable request", i[0], CABLE_REQUEST)
      CABLE_WANT <= 1'b0;
      CABLE_OTHER_REQ <= 1'b0;
      cyc(2);
    end
    $display("test cable requester and parity done");
    for (int i = 0; i < 7; i++) begin
      wr(bus_cfg_pkg::CABLE_TIMEOUT_OFS, {4'h0, WD[i][3:0]});
      {SYS_CONTROLLER, CABLE_MAPS_TO_MAINFRAME, CABLE_SLAVE_RESPONSE} <= WD[i][7:5];
      CABLE_CYCLE_ACTIVE <= 1'b1;
      wait_for(CABLE_TIMEOUT_TERMINATE, 1'b1, ticks(WD[i][3:0]) + 4);
      `CHK("terminate", WD[i][4], CABLE_TIMEOUT_TERMINATE)
      `CHK("not early", 1'b1, t >= ticks(WD[i][3:0]))
      CABLE_CYCLE_ACTIVE <= 1'b0;
      cyc(2);
    end
    $display("test cable watchdog done");
    wr(bus_cfg_pkg::ARB_INTERLOCK_A_OFS, 8'h01);
    wr(bus_cfg_pkg::ARB_INTERLOCK_B_OFS, 8'h01);
    cyc(1);
    `CHK("interlocked", 1'b1, INTERLOCKED)
    CABLE_LOCAL_ACCESS <= 1'b1;
    wait_for(BP_BUSY, 1'b1, 40);
    CABLE_WANT <= 1'b1;
    cyc(3);
    `CHK("cable held off", 1'b0, CABLE_REQUEST)
    CABLE_WANT <= 1'b0;
    CABLE_LOCAL_ACCESS <= 1'b0;
    cyc(2);
    $display("test interlock done");
    give_verdict();
  end
endmodule : bus_requester_timeout_config_tb
